// >>> sdmi_pkg.sv
`default_nettype none
package sdmi_pkg;
  // Byte addresses of the software registers
  localparam logic [7:0] SDMI_ADDR_CTRL   = 8'h00;
  localparam logic [7:0] SDMI_ADDR_STATUS = 8'h04;
  localparam logic [7:0] SDMI_ADDR_IRQ    = 8'h08;
  localparam logic [7:0] SDMI_ADDR_MASK   = 8'h0C;
  localparam logic [7:0] SDMI_ADDR_POS    = 8'h10;

  // Control register fields
  localparam int SDMI_CTRL_RES_LSB   = 0;
  localparam int SDMI_CTRL_RES_W     = 3;
  localparam int SDMI_CTRL_BOOST_BIT = 3;
  localparam int SDMI_CTRL_RSTJ_BIT  = 4;
  localparam int SDMI_CTRL_INV_BIT   = 5;
  localparam int SDMI_CTRL_CLR_BIT   = 6;
  localparam logic [31:0] SDMI_CTRL_RESET = 32'h0000_0001;

  // Interrupt bits
  localparam int SDMI_IRQ_ZERO = 0;
  localparam int SDMI_IRQ_SUP  = 1;
  localparam int SDMI_IRQ_TEMP = 2;
  localparam int SDMI_IRQ_OC   = 3;
  localparam int SDMI_IRQ_W    = 4;

  // Resolution codes
  localparam logic [2:0] SDMI_RES_FULL    = 3'h0;
  localparam logic [2:0] SDMI_RES_HALF    = 3'h1;
  localparam logic [2:0] SDMI_RES_QUARTER = 3'h2;
  localparam logic [2:0] SDMI_RES_FIFTH   = 3'h3;
  localparam logic [2:0] SDMI_RES_TENTH   = 3'h4;
  localparam logic [2:0] SDMI_RES_TWENT   = 3'h5;

  // Step pulse timing from the controller
  localparam int SDMI_CLK_HZ      = 25_000_000;
  localparam int SDMI_STEP_MAX_HZ = 500_000;
  localparam int SDMI_PULSE_NS    = 1000;
  localparam int SDMI_PULSE_CYC   =
    (SDMI_PULSE_NS * (SDMI_CLK_HZ / 1_000_000) + 999) / 1000;

  // Length of the basic position low pulse in cycles
  localparam logic [3:0] SDMI_ZERO_CYC = 4'h4;
  localparam logic [6:0] SDMI_POS_W1   = 7'h01;

  typedef logic [1:0] sdmi_sync_t;
endpackage
`default_nettype wire

// >>> sdmi_sync_if.sv
`default_nettype none
interface sdmi_sync_if;
  logic [6:0] raw;
  logic [6:0] sync;
  modport sync_side (input raw, output sync);
  modport user_side (output raw, input sync);
endinterface
`default_nettype wire

// >>> sdmi_sync.sv
`default_nettype none
module sdmi_sync
(
  input  wire logic  aclk,
  input  wire logic  aresetn,
  sdmi_sync_if.sync_side s
);
  import sdmi_pkg::*;

  typedef struct packed
  {
    logic [6:0] meta;
    logic [6:0] sync;
  } sdmi_sync_st_t;

  sdmi_sync_st_t st_r;
  sdmi_sync_st_t st_nxt;

  always_comb
  begin
    st_nxt      = st_r;
    st_nxt.meta = s.raw;
    st_nxt.sync = st_r.meta;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign s.sync = st_r.sync;
endmodule
`default_nettype wire

// >>> sdmi_top.sv
// The implementer's own choices: the AXI4-Lite register port and the register addresses.
`default_nettype none
// How it works
// RULE1: One step on every falling step edge; rising edges do nothing.
// RULE2: Controller keeps steps at or below 500 kHz, pulses at least 1 us.
// RULE3: An input counts as asserted while its opto input is high.
// RULE4: Direction asserted turns against the preferred direction.
// RULE5: Boost asserted raises run and standstill current by 30 percent.
// RULE6: A switch bit forces boost on permanently.
// RULE7: Phase current flows only while enable is asserted.
// RULE8: Reset input acts only with the jumper set; it clears the counter.
// RULE9: Each accepted reset pulses the basic position output.
// RULE10: Basic position goes low at each counter zero crossing, else high.
// RULE11: Full, half, quarter step zero every 4, 8, 16 pulses.
// RULE12: Fifth, tenth, twentieth step zero every 20, 40, 80 pulses.
// RULE13: Any supply, temperature or current fault shuts the stage down.
// RULE14: Overtemperature shuts the stage down and lights the red lamp.
// RULE15: A switch selects resolution full, 1/2, 1/4, 1/5, 1/10 or 1/20.
// RULE16: Supply fault releases the error output and disables the drive.
// RULE17: Counter moves one position per step, by direction, wraps at modulus.
// RULE18: Steps during a fault are not executed until the fault clears; the code drops them instead of queueing them.
module sdmi_top
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        step_in,
  input  wire logic        dir_in,
  input  wire logic        boost_in,
  input  wire logic        enable_in,
  input  wire logic        reset_in,
  input  wire logic        fault_supply,
  input  wire logic        fault_temp,
  input  wire logic        fault_current,
  output logic             pos_zero_n,
  output logic             err_out_oe,
  output logic             temp_led,
  output logic             drive_on,
  output logic             boost_on,
  output logic             dir_reverse,
  output logic             irq
);
  import sdmi_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  sdmi_sync_if sif ();

  assign sif.raw = {fault_current, fault_temp, fault_supply, reset_in,
                    enable_in, boost_in, step_in};

  sdmi_sync u_sync
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .s       (sif.sync_side)
  );

  logic step_s;
  logic boost_s;
  logic en_s;
  logic rst_s;
  logic f_sup;
  logic f_tmp;
  logic f_oc;

  // RULE3
  assign {f_oc, f_tmp, f_sup, rst_s, en_s, boost_s, step_s} = sif.sync;

  ////////////////////////////////////////////////////////////////////////
  // State

  typedef enum logic [2:0]
  {
    ST_RUN   = 3'h1,
    ST_FAULT = 3'h2,
    ST_RESET = 3'h4
  } sdmi_state_t;

  typedef struct packed
  {
    sdmi_state_t      state;
    logic             step_d;
    logic [1:0]       dir_m;
    logic             dir_s;
    logic [6:0]       pos;
    logic [3:0]       zero_cnt;
    logic [31:0]      ctrl;
    logic [SDMI_IRQ_W-1:0] stat;
    logic [SDMI_IRQ_W-1:0] mask;
    logic             awdone;
    logic             wdone;
    logic [7:0]       awaddr;
    logic [31:0]      wdata;
    logic [3:0]       wstrb;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             rvalid;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
  } sdmi_st_t;

  sdmi_st_t st_r;
  sdmi_st_t st_nxt;

  function automatic logic [6:0] modulus(input logic [2:0] res);
    case (res)
      SDMI_RES_FULL:    modulus = 7'h04; // RULE11
      SDMI_RES_HALF:    modulus = 7'h08; // RULE11
      SDMI_RES_QUARTER: modulus = 7'h10; // RULE11
      SDMI_RES_FIFTH:   modulus = 7'h14; // RULE12
      SDMI_RES_TENTH:   modulus = 7'h28; // RULE12
      default:          modulus = 7'h50; // RULE12
    endcase
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] val,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (be[i])
        r[i*8 +: 8] = val[i*8 +: 8];
    merge = r;
  endfunction

  logic [2:0]  res;
  logic [6:0]  modv;
  logic        fault_any;
  logic        step_fall;
  logic        rst_take;
  logic [SDMI_IRQ_W-1:0] ev;
  logic [31:0] rd_val;
  logic        rd_ok;

  assign res       = st_r.ctrl[SDMI_CTRL_RES_LSB +: SDMI_CTRL_RES_W]; // RULE15
  assign modv      = modulus(res);
  assign fault_any = f_sup | f_tmp | f_oc;
  assign step_fall = st_r.step_d & ~step_s; // RULE1
  assign rst_take  = rst_s & st_r.ctrl[SDMI_CTRL_RSTJ_BIT]; // RULE8

  always_comb
  begin
    rd_val = 32'h0000_0000;
    rd_ok  = 1'b1;
    if (s_axi_araddr[7:0] == SDMI_ADDR_CTRL)
      rd_val = st_r.ctrl;
    else if (s_axi_araddr[7:0] == SDMI_ADDR_STATUS)
      rd_val = {28'h0, fault_any, st_r.state};
    else if (s_axi_araddr[7:0] == SDMI_ADDR_IRQ)
      rd_val = {28'h0, st_r.stat};
    else if (s_axi_araddr[7:0] == SDMI_ADDR_MASK)
      rd_val = {28'h0, st_r.mask};
    else if (s_axi_araddr[7:0] == SDMI_ADDR_POS)
      rd_val = {25'h0, st_r.pos};
    else
      rd_ok = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    st_nxt        = st_r;
    ev            = '0;
    st_nxt.step_d = step_s;
    st_nxt.dir_m  = {st_r.dir_m[0], dir_in};
    st_nxt.dir_s  = st_r.dir_m[1];
    if (st_r.zero_cnt != 4'h0)
      st_nxt.zero_cnt = st_r.zero_cnt - 4'h1;

    case (st_r.state)
      ST_RUN:
      begin
        if (rst_take)
        begin
          // Clear at once so the zero pulse starts with the reset
          st_nxt.state    = ST_RESET;
          st_nxt.pos      = 7'h00; // RULE8
          st_nxt.zero_cnt = SDMI_ZERO_CYC; // RULE9
        end
        else if (fault_any)
          st_nxt.state = ST_FAULT; // RULE13
        else if (step_fall) // RULE1
        begin
          // RULE17
          if (!st_r.dir_s)
            st_nxt.pos = (st_r.pos + SDMI_POS_W1 >= modv) ?
                         7'h00 : st_r.pos + SDMI_POS_W1;
          else
            st_nxt.pos = (st_r.pos == 7'h00) ?
                         modv - SDMI_POS_W1 : st_r.pos - SDMI_POS_W1;
          if (st_nxt.pos == 7'h00)
          begin
            st_nxt.zero_cnt = SDMI_ZERO_CYC; // RULE10
            ev[SDMI_IRQ_ZERO] = 1'b1;
          end
        end
      end
      ST_FAULT:
      begin
        // Steps seen here are dropped, not queued
        if (rst_take)
        begin
          st_nxt.state    = ST_RESET;
          st_nxt.pos      = 7'h00; // RULE8
          st_nxt.zero_cnt = SDMI_ZERO_CYC; // RULE9
        end
        else if (!fault_any)
          st_nxt.state = ST_RUN; // RULE18
      end
      ST_RESET:
      begin
        st_nxt.pos      = 7'h00; // RULE8
        st_nxt.zero_cnt = SDMI_ZERO_CYC; // RULE9
        if (!rst_take)
        begin
          ev[SDMI_IRQ_ZERO] = 1'b1;
          st_nxt.state = fault_any ? ST_FAULT : ST_RUN;
        end
      end
      default:
        st_nxt.state = ST_RUN;
    endcase

    ev[SDMI_IRQ_SUP]  = f_sup;
    ev[SDMI_IRQ_TEMP] = f_tmp;
    ev[SDMI_IRQ_OC]   = f_oc;

    // Bus write channel
    st_nxt.bvalid = st_r.bvalid & ~s_axi_bready;
    if (s_axi_awvalid && !st_r.awdone)
    begin
      st_nxt.awdone = 1'b1;
      st_nxt.awaddr = s_axi_awaddr[7:0];
    end
    if (s_axi_wvalid && !st_r.wdone)
    begin
      st_nxt.wdone = 1'b1;
      st_nxt.wdata = s_axi_wdata;
      st_nxt.wstrb = s_axi_wstrb;
    end
    if (st_r.awdone && st_r.wdone && !st_r.bvalid)
    begin
      st_nxt.awdone = 1'b0;
      st_nxt.wdone  = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp  = 2'b00;
      if (st_r.awaddr == SDMI_ADDR_CTRL)
        st_nxt.ctrl = merge(st_r.ctrl, st_r.wdata, st_r.wstrb);
      else if (st_r.awaddr == SDMI_ADDR_IRQ)
        st_nxt.stat = st_r.stat & ~(st_r.wdata[SDMI_IRQ_W-1:0]
                      & {SDMI_IRQ_W{st_r.wstrb[0]}});
      else if (st_r.awaddr == SDMI_ADDR_MASK)
      begin
        if (st_r.wstrb[0])
          st_nxt.mask = st_r.wdata[SDMI_IRQ_W-1:0];
      end
      else if (st_r.awaddr != SDMI_ADDR_STATUS &&
               st_r.awaddr != SDMI_ADDR_POS)
        st_nxt.bresp = 2'b10;
    end
    // Set wins over a clear in the same cycle
    st_nxt.stat = st_nxt.stat | ev;

    // Bus read channel
    st_nxt.rvalid = st_r.rvalid & ~s_axi_rready;
    if (s_axi_arvalid && !st_r.rvalid)
    begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata  = rd_val;
      st_nxt.rresp  = rd_ok ? 2'b00 : 2'b10;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_r       <= '0;
      st_r.state <= ST_RUN;
      st_r.ctrl  <= SDMI_CTRL_RESET;
    end
    else
      st_r <= st_nxt;
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  assign s_axi_awready = ~st_r.awdone;
  assign s_axi_wready  = ~st_r.wdone;
  assign s_axi_bvalid  = st_r.bvalid;
  assign s_axi_bresp   = st_r.bresp;
  assign s_axi_arready = ~st_r.rvalid;
  assign s_axi_rvalid  = st_r.rvalid;
  assign s_axi_rdata   = st_r.rdata;
  assign s_axi_rresp   = st_r.rresp;

  assign pos_zero_n  = (st_r.zero_cnt == 4'h0); // RULE10
  assign err_out_oe  = ~f_sup; // RULE16
  assign temp_led    = f_tmp; // RULE14
  // Current only while enabled, running and fault free
  assign drive_on    = en_s & (st_r.state == ST_RUN) & ~fault_any; // RULE7
  assign boost_on    = boost_s | st_r.ctrl[SDMI_CTRL_BOOST_BIT]; // RULE5 RULE6
  assign dir_reverse = st_r.dir_s ^ st_r.ctrl[SDMI_CTRL_INV_BIT]; // RULE4
  assign irq         = |(st_r.stat & st_r.mask);

  ////////////////////////////////////////////////////////////////////////
  // Checks

  AST_FALL_ONLY: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_r.state == ST_RUN && !rst_take && !fault_any && !step_fall)
    |=> st_r.pos == $past(st_r.pos)) // RULE1
    else $error("Counter moved without a falling step edge");

  AST_FAULT_OFF: assert property (@(posedge aclk) disable iff (!aresetn)
    fault_any |-> !drive_on) // RULE13
    else $error("Drive on during a fault");

  AST_TEMP_LED: assert property (@(posedge aclk) disable iff (!aresetn)
    f_tmp |-> temp_led && !drive_on) // RULE14
    else $error("Overtemperature not shown");

  AST_SUP_ERR: assert property (@(posedge aclk) disable iff (!aresetn)
    f_sup |-> !err_out_oe && !drive_on) // RULE16
    else $error("Supply fault not released");

  AST_EN_OFF: assert property (@(posedge aclk) disable iff (!aresetn)
    !en_s |-> !drive_on) // RULE7
    else $error("Drive on while disabled");

  AST_RESET_ZERO: assert property (@(posedge aclk) disable iff (!aresetn)
    rst_take |=> st_r.pos == 7'h00 && !pos_zero_n) // RULE8 RULE9
    else $error("Reset did not clear counter");

  AST_WRAP: assert property (@(posedge aclk) disable iff (!aresetn)
    st_r.pos < modv || $changed(res)) // RULE11 RULE12 RULE17
    else $error("Counter beyond modulus");

  AST_NO_FAULT_STEP: assert property (@(posedge aclk) disable iff (!aresetn)
    st_r.state == ST_FAULT && !rst_take
    |=> st_r.pos == $past(st_r.pos)) // RULE18
    else $error("Step taken during fault");

  AST_BOOST: assert property (@(posedge aclk) disable iff (!aresetn)
    st_r.ctrl[SDMI_CTRL_BOOST_BIT] |-> boost_on) // RULE6
    else $error("Forced boost missing");

  AST_DIR: assert property (@(posedge aclk) disable iff (!aresetn)
    !st_r.ctrl[SDMI_CTRL_INV_BIT] |-> dir_reverse == st_r.dir_s) // RULE4
    else $error("Direction output wrong");
endmodule
`default_nettype wire

// >>> sdmi_ctrl_model.sv
`default_nettype none
module sdmi_ctrl_model import sdmi_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       start,
  input  wire logic [7:0] count,
  input  wire logic       dir_req,
  input  wire logic       slow,
  output var  logic       step_out,
  output var  logic       dir_out,
  output var  logic       busy
);
  timeunit 1ns;
  timeprecision 1ns;
  int hi;
  initial
  begin
    step_out = 1'b0;
    dir_out  = 1'b0;
    busy     = 1'b0;
  end
  always @(posedge aclk)
  begin
    if (start)
    begin
      busy    <= 1'b1;
      dir_out <= dir_req;
      // Minimum pulse both ways gives the top step rate
      hi = slow ? 2 * SDMI_PULSE_CYC : SDMI_PULSE_CYC;
      // Direction settles through its sync chain first
      repeat (4) @(posedge aclk);
      repeat (count)
      begin
        step_out <= 1'b1;
        repeat (hi) @(posedge aclk);
        step_out <= 1'b0;
        repeat (hi) @(posedge aclk);
      end
      busy <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// >>> sdmi_bench.sv
`default_nettype none
module sdmi_bench import sdmi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed
  {
    logic [1:0]  resp;
    logic [31:0] data;
    logic [31:0] mask;
  } sdmi_rd_t;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [3:0]  wstrb = 4'hF;
  logic        step_in, dir_in, m_busy;
  logic        m_start = 1'b0, m_dir = 1'b0, m_slow = 1'b0;
  logic [7:0]  m_count = '0;
  logic        boost_in = 1'b0, enable_in = 1'b0, reset_in = 1'b0;
  logic        f_sup = 1'b0, f_tmp = 1'b0, f_cur = 1'b0;
  logic        pos_zero_n, err_out_oe, temp_led, drive_on;
  logic        boost_on, dir_reverse, irq;
  logic        pz_d = 1'b1, st_d = 1'b0;
  logic [31:0] seed = 32'h7F06;
  sdmi_rd_t    rd_q[$];
  logic [1:0]  wr_q[$];
  int          zero_q[$];
  int          mods[6] = '{4, 8, 16, 20, 40, 80};
  int          error_cnt = 0, n_tests = 0, stp_cnt = 0, cyc = 0;

  sdmi_top u_sdmi_top
  (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .step_in(step_in), .dir_in(dir_in), .boost_in(boost_in),
    .enable_in(enable_in), .reset_in(reset_in), .fault_supply(f_sup),
    .fault_temp(f_tmp), .fault_current(f_cur), .pos_zero_n(pos_zero_n),
    .err_out_oe(err_out_oe), .temp_led(temp_led), .drive_on(drive_on),
    .boost_on(boost_on), .dir_reverse(dir_reverse), .irq(irq)
  );
  sdmi_ctrl_model u_sdmi_ctrl_model
  (
    .aclk(aclk), .start(m_start), .count(m_count), .dir_req(m_dir),
    .slow(m_slow), .step_out(step_in), .dir_out(dir_in), .busy(m_busy)
  );
  always #20 aclk = ~aclk;

  ////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    if (error_cnt == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(string s, logic [31:0] e, logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", s, e, g);
    end
  endtask
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic wt(int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic axi_wr(logic [7:0] a, logic [31:0] d, logic [1:0] r);
    wr_q.push_back(r);
    awaddr  <= {24'h0, a};
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end
    while (!bvalid);
    bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic axi_rd(logic [7:0] a, logic [31:0] e, logic [31:0] m,
                        logic [1:0] r);
    rd_q.push_back('{r, e, m});
    araddr  <= {24'h0, a};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready)
        arvalid <= 1'b0;
    end
    while (!rvalid);
    rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic steps(int n, logic d);
    m_count <= 8'(n);
    m_dir   <= d;
    m_slow  <= ^rnd();
    m_start <= 1'b1;
    @(posedge aclk);
    m_start <= 1'b0;
    @(posedge aclk);
    while (m_busy)
      @(posedge aclk);
    wt(6);
  endtask
  task automatic pulse_rst(logic z);
    if (z)
      zero_q.push_back(stp_cnt);
    reset_in <= 1'b1;
    wt(6);
    reset_in <= 1'b0;
    wt(8);
  endtask

  ////////////////////////////////////////////////////////////////////////
  always @(posedge aclk)
  begin
    sdmi_rd_t e;
    cyc++;
    if (cyc == 40000)
    begin
      error_cnt++;
      stop_test();
    end
    if (aresetn)
    begin
      if (bvalid && bready)
        chk("bresp", wr_q.size() ? wr_q.pop_front() : 2'h3, bresp);
      if (rvalid && rready)
      begin
        e = rd_q.pop_front();
        chk("rresp", 32'(e.resp), 32'(rresp));
        chk("rdata", e.data, rdata & e.mask);
      end
      if (pz_d && !pos_zero_n)
        chk("zero", zero_q.size() ? zero_q.pop_front() : -1, stp_cnt);
      if (st_d && !step_in)
        stp_cnt++;
    end
    pz_d = pos_zero_n;
    st_d = step_in;
  end

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    int k;
    wt(8);
    aresetn <= 1'b1;
    @(posedge aclk);
    axi_rd(SDMI_ADDR_CTRL, SDMI_CTRL_RESET, 32'hFFFF_FFFF, 2'h0);
    axi_rd(8'h40, 32'h0, 32'h0, 2'h2);
    axi_wr(8'h40, 32'h0, 2'h2);
    axi_wr(SDMI_ADDR_MASK, 32'h0, 2'h0);
    enable_in <= 1'b1;
    wt(5);
    chk("drive_on", 1, drive_on);
    enable_in <= 1'b0;
    wt(5);
    chk("drive_on", 0, drive_on);
    enable_in <= 1'b1;
    for (int r = 0; r < 6; r++)
    begin
      axi_wr(SDMI_ADDR_CTRL, 32'h10 | 32'(r), 2'h0);
      pulse_rst(1'b1);
      zero_q.push_back(stp_cnt + mods[r]);
      steps(mods[r], 1'b0);
      axi_rd(SDMI_ADDR_POS, 32'h0, 32'h7F, 2'h0);
    end
    // Backward at half step from zero wraps to the top
    axi_wr(SDMI_ADDR_CTRL, 32'h11, 2'h0);
    pulse_rst(1'b1);
    steps(1, 1'b1);
    axi_rd(SDMI_ADDR_POS, 32'h7, 32'h7F, 2'h0);
    zero_q.push_back(stp_cnt + 7);
    steps(7, 1'b1);
    chk("dir_reverse", 1, dir_reverse);
    axi_wr(SDMI_ADDR_CTRL, 32'h31, 2'h0);
    wt(3);
    chk("dir_reverse", 0, dir_reverse);
    // Without the jumper the reset pin must be ignored
    axi_wr(SDMI_ADDR_CTRL, 32'h01, 2'h0);
    k = 1 + int'(rnd() % 3);
    steps(k, 1'b0);
    pulse_rst(1'b0);
    axi_rd(SDMI_ADDR_POS, 32'(k), 32'h7F, 2'h0);
    boost_in <= 1'b1;
    wt(5);
    chk("boost_on", 1, boost_on);
    boost_in <= 1'b0;
    axi_wr(SDMI_ADDR_CTRL, 32'h09, 2'h0);
    wt(5);
    chk("boost_on", 1, boost_on);
    axi_wr(SDMI_ADDR_CTRL, 32'h01, 2'h0);
    wt(3);
    chk("boost_on", 0, boost_on);
    // No byte lanes enabled: control must keep its value
    wstrb <= 4'h0;
    axi_wr(SDMI_ADDR_CTRL, 32'h3F, 2'h0);
    wstrb <= 4'hF;
    axi_rd(SDMI_ADDR_CTRL, 32'h01, 32'hFFFF_FFFF, 2'h0);
    axi_wr(SDMI_ADDR_IRQ, 32'hF, 2'h0);
    f_tmp <= 1'b1;
    wt(5);
    chk("temp_led", 1, temp_led);
    chk("drive_on", 0, drive_on);
    axi_rd(SDMI_ADDR_STATUS, 32'hA, 32'hF, 2'h0);
    steps(2, 1'b0);
    f_tmp <= 1'b0;
    wt(5);
    axi_rd(SDMI_ADDR_POS, 32'(k), 32'h7F, 2'h0);
    chk("drive_on", 1, drive_on);
    f_sup <= 1'b1;
    wt(5);
    chk("err_out_oe", 0, err_out_oe);
    chk("drive_on", 0, drive_on);
    f_sup <= 1'b0;
    f_cur <= 1'b1;
    wt(5);
    chk("drive_on", 0, drive_on);
    chk("err_out_oe", 1, err_out_oe);
    f_cur <= 1'b0;
    wt(5);
    axi_rd(SDMI_ADDR_IRQ, 32'hE, 32'hF, 2'h0);
    chk("irq", 0, irq);
    axi_wr(SDMI_ADDR_MASK, 32'h4, 2'h0);
    wt(2);
    chk("irq", 1, irq);
    axi_wr(SDMI_ADDR_IRQ, 32'h4, 2'h0);
    wt(2);
    chk("irq", 0, irq);
    axi_rd(SDMI_ADDR_IRQ, 32'hA, 32'hF, 2'h0);
    wt(5);
    chk("zero_left", 0, zero_q.size());
    stop_test();
  end
endmodule
`default_nettype wire
